// >>> pss_pkg.sv
// Constants for the power-save and wake-up controller.
// Assumes one 125 MHz clock and an APB slave with one word per register.
`default_nettype none
package pss_pkg;
  // ----------------------------------------
  // Register map (index, byte address = 4 x index)
  // ----------------------------------------
  localparam logic [15:0] IDX_RST_STATUS = 16'h0740;
  localparam logic [15:0] IDX_OSC_CTRL   = 16'h0742;
  localparam logic [15:0] IDX_OSC_TUNE   = 16'h0744;
  localparam logic [15:0] IDX_IDLE_RUN   = 16'h0746;
  // Reset cause and power status fields
  localparam int          B_TRAP     = 15;
  localparam int          B_ILLOP    = 14;
  localparam int          B_EXT      = 7;
  localparam int          B_SW       = 6;
  localparam int          B_SW_WD    = 5;
  localparam int          B_WD_TO    = 4;
  localparam int          B_SLEEP    = 3;
  localparam int          B_IDLE     = 2;
  localparam int          B_BROWN    = 1;
  localparam int          B_PWRON    = 0;
  localparam logic [15:0] RS_RST     = 16'h0003;
  localparam logic [15:0] RS_WMASK   = 16'hE0FF;
  // Oscillator control fields
  localparam int          B_CUR_OSC  = 12;
  localparam int          B_LOCK     = 5;
  localparam int          B_CLK_FAIL = 3;
  localparam int          B_LPX_KEEP = 1;
  localparam int          TUNE_W     = 4;
  // Oscillator kinds held in the current-oscillator field
  localparam logic [1:0]  OSC_LPX    = 2'h0;
  localparam logic [1:0]  OSC_FAST   = 2'h1;
  localparam logic [1:0]  OSC_LOW_POWER_RC_CLOCK   = 2'h2;
  localparam logic [1:0]  OSC_PRI    = 2'h3;
  localparam int          PM_XTAL    = 2;
  localparam int          PM_PLL     = 3;
  // Power-save instruction operand
  localparam logic        PSV_SLEEP  = 1'b0;
  localparam logic        PSV_IDLE   = 1'b1;
  // Power mode report
  localparam logic [1:0]  MODE_RUN   = 2'h0;
  localparam logic [1:0]  MODE_IDLE  = 2'h1;
  localparam logic [1:0]  MODE_SLEEP = 2'h2;
  localparam logic [1:0]  MODE_WAKE  = 2'h3;
  // ----------------------------------------
  // Configuration words
  // ----------------------------------------
  localparam int          CFG_WORD_W = 24;
  localparam int          CFG_DATA_W = 16;
  localparam logic [2:0]  CW_OSC     = 3'h0;
  localparam logic [2:0]  CW_WD      = 3'h1;
  localparam logic [2:0]  CW_BROWN   = 3'h2;
  localparam int          CW_MON_EN  = 15;
  localparam int          CW_SW_EN   = 14;
  localparam int          CW_FAMILY  = 8;
  localparam int          CW_WD_EN   = 15;
  localparam int          CW_BRN_EN  = 7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_NS       = 8;
  localparam int          T_PWRON_NS   = 10000;
  localparam int          PWRON_CYC    = (T_PWRON_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] PWRON_LOAD   = 16'(PWRON_CYC - 1);
  localparam int          PWRUP_CYC_DF = 16;
  localparam int          OSTRT_CYC_DF = 64;
  localparam int          LOCK_CYC_DF  = 32;
  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_SLEEP, ST_PWRON, ST_PWRUP, ST_OSTRT, ST_LOCK, ST_STALL
  } pss_state_e;
endpackage : pss_pkg
`default_nettype wire

// >>> pss_power_save_wakeup_control.sv
// Power-save state control, wake-up sequencing and reset status flags.
// Assumes pin and foreign-clock inputs are asynchronous; the rest is on clk.
//
// What this block does
// - Two low-power states, deep sleep and light idle, entered only by the instruction.
// - Deep sleep gates processor and peripheral clocks and stops the on-chip oscillator.
// - Fail-safe monitor off in sleep; low-power RC runs while the watchdog works.
// - Brown-out and low-voltage detection stay active in sleep when enabled.
// - Sleep ends on enabled interrupt, any reset source or watchdog time-out.
// - Sleep wake restarts the prior clock; switching lets software pick it.
// - Power-on or brown-out wake takes the oscillator from configuration fields.
// - Oscillator wake waits power-on, power-up and start-up, plus PLL lock time.
// - External clock and RC sources wake after only the power-on delay.
// - A kept low-power crystal wakes after only the power-on delay.
// - Clock dead after delays: trap and fast RC if monitored, else stall.
// - Resets wake sleep; non power-on reset sets sleep flag, power-on clears.
// - Watchdog time-out in sleep wakes and sets sleep and time-out flags.
// - Light idle stops the processor clock and each peripheral clock whose run-in-idle bit is clear.
// - Each peripheral has its own run-in-idle control bit.
// - Low-power RC keeps running in idle while failure detection is on.
// - Idle ends on enabled interrupt, any reset source or watchdog time-out.
// - Idle wake resumes at once; an interrupt wake vectors first.
// - Idle flag set on interrupt wake and non power-on reset; power-on clears.
// - Watchdog time-out in idle wakes and sets idle and time-out flags.
// - Idle wake has no start-up, lock or power-up delay.
// - Configuration words read as 24 bits with data in the low 16.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pss_power_save_wakeup_control #(
  parameter int N_PERIPH  = 8,
  parameter int PWRUP_CYC = pss_pkg::PWRUP_CYC_DF,
  parameter int OSTRT_CYC = pss_pkg::OSTRT_CYC_DF,
  parameter int LOCK_CYC  = pss_pkg::LOCK_CYC_DF
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [17:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output var  logic [31:0]                         prdata,
  output var  logic                                pready,
  output var  logic                                pslverr,
  input  wire logic                                pwrsavValid,
  input  wire logic                                pwrsavOperand,
  input  wire logic                                irqWake,
  input  wire logic                                swReset,
  input  wire logic                                powerOnDet,
  input  wire logic                                brownOutDet,
  input  wire logic                                extResetPin,
  input  wire logic                                watchdogTimeout,
  input  wire logic                                oscStable,
  input  wire logic                                pllLocked,
  input  wire logic [1:0]                          cfgOscFamily,
  input  wire logic [3:0]                          cfgPrimaryMode,
  input  wire logic                                cfgFailSafeEn,
  input  wire logic                                cfgClkSwitchEn,
  input  wire logic                                cfgWatchdogEn,
  input  wire logic                                cfgBrownOutEn,
  input  wire logic                                lowVoltDetectEn,
  input  wire logic                                cfgRdReq,
  input  wire logic [2:0]                          cfgRdIdx,
  output var  logic [pss_pkg::CFG_WORD_W-1:0]      cfgRdData,
  output var  logic                                cpuClkEn,
  output var  logic [N_PERIPH-1:0]                 periphClkEn,
  output var  logic                                oscRun,
  output var  logic                                lowPowerRcRun,
  output var  logic                                failSafeActive,
  output var  logic                                brownOutActive,
  output var  logic                                lowVoltActive,
  output var  logic                                fastRcForce,
  output var  logic                                clkFailTrap,
  output var  logic                                resume,
  output var  logic                                vectorIrq,
  output var  logic [1:0]                          powerMode,
  output var  logic [pss_pkg::TUNE_W-1:0]          oscTune
);
  import pss_pkg::*;

  if (N_PERIPH < 1 || N_PERIPH > 16) begin : g_bad_np
    $error("N_PERIPH must be 1 to 16");
  end
  if (PWRUP_CYC < 1 || OSTRT_CYC < 1 || LOCK_CYC < 1 ||
      PWRUP_CYC > 65536 || OSTRT_CYC > 65536 || LOCK_CYC > 65536) begin : g_bad_cyc
    $error("delay counts must be 1 to 65536");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] asyncIn;
  logic [NS-1:0] syncA_q;
  logic [NS-1:0] syncB_q;
  logic [NS-1:0] prevB_q;
  logic [NS-1:0] rise;
  assign asyncIn = {pllLocked, oscStable, watchdogTimeout, extResetPin, brownOutDet, powerOnDet};

  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge clk) begin
      syncA_q[i] <= rst ? 1'b0 : asyncIn[i];
      syncB_q[i] <= rst ? 1'b0 : syncA_q[i];
      prevB_q[i] <= rst ? 1'b0 : syncB_q[i];
    end
    assign rise[i] = syncB_q[i] & ~prevB_q[i];
  end

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  pss_state_e    state_q;
  pss_state_e    state_d;
  pss_state_e    endState;
  logic [15:0]   cnt_q;
  logic [15:0]   cnt_d;
  logic [15:0]   rs_q;
  logic [15:0]   rs_d;
  logic [1:0]    curOsc_q;
  logic [1:0]    curOsc_d;
  logic          lpxKeep_q;
  logic          lpxKept_q;
  logic          clkFail_q;
  logic          irqCause_q;
  logic [N_PERIPH-1:0] idleRun_q;
  wire           oscOk      = syncB_q[4];
  wire           pllOk      = syncB_q[5];
  wire           porEv      = rise[0];
  wire           brownEv    = rise[1] & cfgBrownOutEn & ~porEv;
  wire           extEv      = rise[2];
  wire           cfgRstEv   = porEv | brownEv;
  wire           anyRst     = cfgRstEv | extEv | swReset;
  wire           watchdogOn = cfgWatchdogEn | rs_q[B_SW_WD];
  wire           wdEv       = rise[3] & watchdogOn;
  wire           inRun      = state_q == ST_RUN;
  wire           inIdle     = state_q == ST_IDLE;
  wire           inSleep    = state_q == ST_SLEEP;
  wire           anyWake    = irqWake | anyRst | wdEv;
  wire           irqOnly    = irqWake & ~anyRst & ~wdEv;
  // Register decode, declared ahead of the status and oscillator logic
  wire           setup      = psel & ~penable;
  wire           hitSt      = paddr[17:2] == IDX_RST_STATUS;
  wire           hitOsc     = paddr[17:2] == IDX_OSC_CTRL;
  wire           hitTune    = paddr[17:2] == IDX_OSC_TUNE;
  wire           hitIdle    = paddr[17:2] == IDX_IDLE_RUN;
  wire           hit        = hitSt | hitOsc | hitTune | hitIdle;
  wire           wrAcc      = psel & penable & pwrite & pready;
  wire           wrStatus   = wrAcc & hitSt;
  wire           wrOsc      = wrAcc & hitOsc;
  wire           wrTune     = wrAcc & hitTune;
  wire           wrIdle     = wrAcc & hitIdle;
  // Power-save instruction decode
  wire           enterSleep = inRun & pwrsavValid & (pwrsavOperand == PSV_SLEEP);
  wire           enterIdle  = inRun & pwrsavValid & (pwrsavOperand == PSV_IDLE);
  wire           sleepWake  = inSleep & anyWake;
  wire           idleWake   = inIdle & anyWake;
  wire           cntZero    = cnt_q == 16'h0000;
  wire           lpxKeepNow = lpxKeep_q & (curOsc_q == OSC_LPX);
  // Crystal sources need the full delay chain unless the crystal was kept
  wire           pllUse     = (curOsc_q == OSC_PRI) & cfgPrimaryMode[PM_PLL];
  wire           needStart  = ((curOsc_q == OSC_PRI) &
                              (cfgPrimaryMode[PM_PLL] | cfgPrimaryMode[PM_XTAL])) |
                              ((curOsc_q == OSC_LPX) & ~lpxKept_q);
  wire           clkOk      = pllUse ? pllOk : (needStart ? oscOk : 1'b1);
  wire           delayDone  = ~cfgRstEv & cntZero &
                              (((state_q == ST_PWRON) & ~needStart) |
                               ((state_q == ST_OSTRT) & ~pllUse) |
                               (state_q == ST_LOCK));
  wire           trapTake   = delayDone & ~clkOk & cfgFailSafeEn;
  assign endState = (clkOk | cfgFailSafeEn) ? ST_RUN : ST_STALL;

  // ----------------------------------------
  // Power state sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cntZero ? cnt_q : cnt_q - 16'h0001;
    if (cfgRstEv) begin
      state_d = ST_PWRON;
      cnt_d   = PWRON_LOAD;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (enterSleep) state_d = ST_SLEEP;
          else if (enterIdle) state_d = ST_IDLE;
        end
        ST_IDLE: begin
          if (idleWake) state_d = ST_RUN;
        end
        ST_SLEEP: begin
          if (sleepWake) begin
            state_d = ST_PWRON;
            cnt_d   = PWRON_LOAD;
          end
        end
        ST_PWRON: begin
          if (cntZero && needStart) begin
            state_d = ST_PWRUP;
            cnt_d   = 16'(PWRUP_CYC - 1);
          end else if (cntZero) begin
            state_d = endState;
          end
        end
        ST_PWRUP: begin
          if (cntZero) begin
            state_d = ST_OSTRT;
            cnt_d   = 16'(OSTRT_CYC - 1);
          end
        end
        ST_OSTRT: begin
          if (cntZero && pllUse) begin
            state_d = ST_LOCK;
            cnt_d   = 16'(LOCK_CYC - 1);
          end else if (cntZero) begin
            state_d = endState;
          end
        end
        ST_LOCK: begin
          if (cntZero) state_d = endState;
        end
        ST_STALL: begin
          if (clkOk) state_d = ST_RUN;
        end
        default: state_d = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_q <= rst ? ST_RUN : state_d;
    cnt_q   <= rst ? 16'h0000 : cnt_d;
  end

  // ----------------------------------------
  // Reset cause and power status flags
  // ----------------------------------------
  // Hardware updates follow the software write so that a set wins.
  wire setSleep = inSleep & (anyRst | wdEv | irqWake);
  wire setIdle  = inIdle & (anyRst | wdEv | irqWake);

  always_comb begin
    rs_d = rs_q;
    if (wrStatus) rs_d = pwdata[15:0] & RS_WMASK;
    if (extEv) begin
      rs_d[B_EXT]   = 1'b1;
      rs_d[B_WD_TO] = 1'b0;
    end
    if (swReset) begin
      rs_d[B_SW]    = 1'b1;
      rs_d[B_EXT]   = 1'b0;
      rs_d[B_WD_TO] = 1'b0;
    end
    if (brownEv) begin
      rs_d[B_BROWN] = 1'b1;
      rs_d[B_PWRON] = 1'b0;
    end
    if (wdEv) rs_d[B_WD_TO] = 1'b1;
    if (setSleep) rs_d[B_SLEEP] = 1'b1;
    if (setIdle) rs_d[B_IDLE] = 1'b1;
    if (porEv) rs_d = RS_RST;
  end

  // ----------------------------------------
  // Oscillator selection
  // ----------------------------------------
  always_comb begin
    curOsc_d = curOsc_q;
    if (wrOsc && cfgClkSwitchEn) curOsc_d = pwdata[B_CUR_OSC +: 2];
    if (trapTake) curOsc_d = OSC_FAST;
    if (cfgRstEv) curOsc_d = cfgOscFamily;
  end

  always_ff @(posedge clk) begin
    rs_q       <= rst ? RS_RST : rs_d;
    curOsc_q   <= rst ? OSC_FAST : curOsc_d;
    lpxKeep_q  <= rst ? 1'b0 : (wrOsc ? pwdata[B_LPX_KEEP] : lpxKeep_q);
    clkFail_q  <= rst ? 1'b0 : (trapTake | (wrOsc ? pwdata[B_CLK_FAIL] : clkFail_q));
    oscTune    <= rst ? '0 : (wrTune ? pwdata[TUNE_W-1:0] : oscTune);
    idleRun_q  <= rst ? '0 : (wrIdle ? pwdata[N_PERIPH-1:0] : idleRun_q);
    lpxKept_q  <= (rst | cfgRstEv) ? 1'b0 : (enterSleep ? lpxKeepNow : lpxKept_q);
    irqCause_q <= (rst | cfgRstEv) ? 1'b0 : (sleepWake ? irqOnly : irqCause_q);
  end

  // ----------------------------------------
  // Clock gates and wake pulses
  // ----------------------------------------
  wire runNext   = state_d == ST_RUN;
  wire idleNext  = state_d == ST_IDLE;
  wire sleepNext = state_d == ST_SLEEP;
  wire wakeNow   = runNext & ~inRun;

  for (genvar p = 0; p < N_PERIPH; p++) begin : g_periph
    always_ff @(posedge clk) begin
      periphClkEn[p] <= rst ? 1'b1 : (runNext | (idleNext & idleRun_q[p]));
    end
  end

  always_ff @(posedge clk) begin
    cpuClkEn       <= rst ? 1'b1 : runNext;
    oscRun         <= rst ? 1'b1 : (~sleepNext | lpxKeepNow);
    lowPowerRcRun  <= rst ? 1'b0 : (watchdogOn | (cfgFailSafeEn & ~sleepNext));
    failSafeActive <= rst ? 1'b0 : (cfgFailSafeEn & ~sleepNext);
    brownOutActive <= rst ? 1'b0 : cfgBrownOutEn;
    lowVoltActive  <= rst ? 1'b0 : lowVoltDetectEn;
    fastRcForce    <= (rst | cfgRstEv) ? 1'b0 : (fastRcForce | trapTake);
    clkFailTrap    <= rst ? 1'b0 : trapTake;
    resume         <= rst ? 1'b0 : wakeNow;
    vectorIrq      <= rst ? 1'b0 : (wakeNow & (inIdle ? irqOnly : irqCause_q));
    powerMode      <= rst ? MODE_RUN : (runNext ? MODE_RUN : idleNext ? MODE_IDLE :
                                        sleepNext ? MODE_SLEEP : MODE_WAKE);
  end

  // ----------------------------------------
  // Configuration word read
  // ----------------------------------------
  logic [CFG_DATA_W-1:0] cfgWord;
  always_comb begin
    cfgWord = '0;
    case (cfgRdIdx)
      CW_OSC: begin
        cfgWord[CW_MON_EN]        = cfgFailSafeEn;
        cfgWord[CW_SW_EN]         = cfgClkSwitchEn;
        cfgWord[CW_FAMILY +: 2]   = cfgOscFamily;
        cfgWord[3:0]              = cfgPrimaryMode;
      end
      CW_WD:    cfgWord[CW_WD_EN]  = cfgWatchdogEn;
      CW_BROWN: cfgWord[CW_BRN_EN] = cfgBrownOutEn;
      default:  cfgWord = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    cfgRdData <= rst ? '0 : (cfgRdReq ? {8'h00, cfgWord} : cfgRdData);
  end

  // ----------------------------------------
  // APB slave, one wait-free access cycle
  // ----------------------------------------
  logic [15:0] oscView;
  logic [15:0] rdMux;
  always_comb begin
    oscView = '0;
    oscView[B_CUR_OSC +: 2] = curOsc_q;
    oscView[B_LOCK]         = pllOk;
    oscView[B_CLK_FAIL]     = clkFail_q;
    oscView[B_LPX_KEEP]     = lpxKeep_q;
    rdMux = '0;
    if (hitSt) rdMux = rs_q;
    if (hitOsc) rdMux = oscView;
    if (hitTune) rdMux[TUNE_W-1:0] = oscTune;
    if (hitIdle) rdMux[N_PERIPH-1:0] = idleRun_q;
  end

  always_ff @(posedge clk) begin
    pready  <= rst ? 1'b0 : setup;
    pslverr <= rst ? 1'b0 : (setup & ~hit);
    prdata  <= rst ? 32'h0000_0000 : (setup ? {16'h0000, rdMux} : prdata);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [15:0] dwell_q;
  always_ff @(posedge clk) begin
    dwell_q <= (rst || state_q != ST_PWRON) ? 16'h0000 : dwell_q + 16'h0001;
  end
  sequence s_idleIrq;
    inIdle && irqOnly;
  endsequence
  sequence s_vectorOnce;
    resume && vectorIrq ##1 !resume && !vectorIrq;
  endsequence

  a_cmd_entry: assert property (enterSleep && !cfgRstEv |=> inSleep && !cpuClkEn)
    else $error("sleep not entered");
  a_sleep_clk_off: assert property (inSleep |-> !cpuClkEn && periphClkEn == '0)
    else $error("clock runs in sleep");
  a_idle_cpu_only: assert property (inIdle |-> !cpuClkEn && periphClkEn == $past(idleRun_q))
    else $error("idle gating wrong");
  a_failsafe_sleep: assert property (inSleep |-> !failSafeActive)
    else $error("monitor active in sleep");
  a_pwron_delay: assert property ($fell(state_q == ST_PWRON) && !cfgRstEv |->
                                  $past(dwell_q) == 16'(PWRON_CYC - 1))
    else $error("power-on delay length wrong");
  a_idle_no_delay: assert property (idleWake && !cfgRstEv |=> inRun ##1 inRun || !resume)
    else $error("idle wake delayed");
  a_idle_vector: assert property (s_idleIrq |=> s_vectorOnce)
    else $error("idle interrupt not vectored");
  a_wd_sleep_flags: assert property (inSleep && wdEv && !porEv |=> rs_q[B_WD_TO] && rs_q[B_SLEEP])
    else $error("sleep watchdog flags");
  a_wd_idle_flags: assert property (inIdle && wdEv && !porEv |=> rs_q[B_WD_TO] && rs_q[B_IDLE])
    else $error("idle watchdog flags");
  a_por_clears: assert property (porEv |=> !rs_q[B_SLEEP] && !rs_q[B_IDLE] && rs_q[B_PWRON])
    else $error("power-on flags wrong");
  a_trap_fast: assert property (trapTake |=> clkFailTrap && fastRcForce && curOsc_q == OSC_FAST)
    else $error("clock failure trap missed");
endmodule : pss_power_save_wakeup_control
`default_nettype wire

// >>> pss_testbench.sv
// Self-checking bench for the power-save and wake-up controller.
// Assumes the design files are compiled first; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pss_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, pwrsavValid = 0, pwrsavOperand = 0, irqWake = 0;
  logic swReset = 0, powerOnDet = 0, extResetPin = 0, watchdogTimeout = 0;
  logic [23:0] cfgRdData;
  logic cfgRdReq = 0, cpuClkEn, oscRun, resume, vectorIrq;
  logic brownOutDet = 0, oscStable = 1, pllLocked = 1, cfgFailSafeEn = 0;
  logic [3:0] cfgPrimaryMode = '0;
  logic [2:0] cfgRdIdx = '0;
  logic [7:0] periphClkEn;
  logic [1:0] powerMode;
  int mismatches = 0, checks_done = 0, n;
  pss_power_save_wakeup_control #(.PWRUP_CYC(2), .OSTRT_CYC(2), .LOCK_CYC(2)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwrsavValid(pwrsavValid), .pwrsavOperand(pwrsavOperand), .irqWake(irqWake),
    .swReset(swReset), .powerOnDet(powerOnDet), .brownOutDet(brownOutDet),
    .extResetPin(extResetPin), .watchdogTimeout(watchdogTimeout), .oscStable(oscStable),
    .pllLocked(pllLocked), .cfgOscFamily(2'h1), .cfgPrimaryMode(cfgPrimaryMode),
    .cfgFailSafeEn(cfgFailSafeEn),
    .cfgClkSwitchEn(1'b1), .cfgWatchdogEn(1'b1), .cfgBrownOutEn(1'b1),
    .lowVoltDetectEn(1'b1), .cfgRdReq(cfgRdReq), .cfgRdIdx(cfgRdIdx), .cfgRdData(cfgRdData),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .oscRun(oscRun), .lowPowerRcRun(),
    .failSafeActive(), .brownOutActive(), .lowVoltActive(), .fastRcForce(),
    .clkFailTrap(), .resume(resume), .vectorIrq(vectorIrq), .powerMode(powerMode),
    .oscTune());
  always #4 clk = ~clk;
  task end_sim;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : apb
  task status(input logic [15:0] x);
    apb(0, 18'h01D00, 0);
    chk(rd, {16'h0, x});
    apb(1, 18'h01D00, 0);
  endtask : status
  task enter(input logic op);
    @(posedge clk); pwrsavValid <= 1; pwrsavOperand <= op;
    @(posedge clk); pwrsavValid <= 0;
    @(negedge clk);
    chk(cpuClkEn, 0);
    chk(powerMode, op ? MODE_IDLE : MODE_SLEEP);
    chk(oscRun, op);
  endtask : enter
  task wake(input int lim);
    n = 0;
    while (resume !== 1'b1 && n < lim) begin
      @(negedge clk); n++;
    end
    chk(resume, 1);
    chk(cpuClkEn, 1);
  endtask : wake
  task t_basic;
    status(RS_RST);
    apb(0, 18'h00040, 0);
    chk(er, 1);
    chk(rd, 0);
    @(posedge clk); cfgRdReq <= 1;
    @(posedge clk); cfgRdReq <= 0; cfgRdIdx <= CW_WD;
    @(negedge clk);
    chk(cfgRdData, 24'h004100);
    @(posedge clk); cfgRdReq <= 1;
    @(posedge clk); cfgRdReq <= 0;
    @(negedge clk);
    chk(cfgRdData, 24'h008000);
  endtask : t_basic
  task t_idle_irq;
    enter(PSV_IDLE);
    @(posedge clk); irqWake <= 1;
    @(posedge clk);
    @(negedge clk);
    chk({resume, vectorIrq, cpuClkEn}, 3'b111);
    @(posedge clk); irqWake <= 0;
    status(16'h0004);
  endtask : t_idle_irq
  task t_idle_wdog;
    enter(PSV_IDLE);
    @(posedge clk); watchdogTimeout <= 1;
    wake(10);
    chk(vectorIrq, 0);
    @(posedge clk); watchdogTimeout <= 0;
    status(16'h0014);
  endtask : t_idle_wdog
  task t_sleep_irq;
    enter(PSV_SLEEP);
    chk(periphClkEn, 8'h00);
    @(posedge clk); irqWake <= 1;
    wake(1400);
    // Fast RC wake: only the power-on delay applies
    chk(n >= PWRON_CYC - 1 && n <= PWRON_CYC + 6, 1);
    @(posedge clk); irqWake <= 0;
    status(16'h0008);
  endtask : t_sleep_irq
  // Primary PLL source that never locks, with the fail-safe monitor on
  task t_sleep_trap;
    pllLocked <= 0; cfgPrimaryMode <= 4'h8; cfgFailSafeEn <= 1;
    apb(1, 18'h01D08, 32'h0000_3000);
    enter(PSV_SLEEP);
    @(posedge clk); irqWake <= 1;
    wake(1400);
    chk(n >= PWRON_CYC + 5, 1);
    @(posedge clk); irqWake <= 0;
    apb(0, 18'h01D08, 0);
    chk(rd, 32'h0000_1008);
    pllLocked <= 1; cfgFailSafeEn <= 0; cfgPrimaryMode <= 4'h0;
    apb(1, 18'h01D08, 32'h0000_1000);
    status(16'h0008);
  endtask : t_sleep_trap
  task t_sleep_rst(input logic por);
    enter(PSV_SLEEP);
    @(posedge clk);
    if (por) powerOnDet <= 1;
    else extResetPin <= 1;
    wake(1400);
    @(posedge clk); powerOnDet <= 0; extResetPin <= 0;
    status(por ? RS_RST : 16'h0088);
  endtask : t_sleep_rst
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_basic;
    t_idle_irq;
    t_idle_wdog;
    t_sleep_irq;
    t_sleep_trap;
    t_sleep_rst(0);
    t_sleep_rst(1);
    end_sim;
  end
  initial begin
    #(8 * 20000);
    mismatches++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
